// >>> acs_pkg.sv
// Shared constants, types and carriers of the conversion sequencer
package acs_pkg;

    localparam int AXI_AW = 16;
    localparam int CNT_W  = 13;
    localparam int RES_W  = 10;
    localparam int SEL_W  = 4;
    localparam int PIN_N  = 12;

    // Printed offset is not word aligned: kept as index, byte address is four times it
    localparam logic [11:0]       BASE_REG_INDEX = 12'hFBD;
    localparam logic [AXI_AW-1:0] BASE_ADDR      = {2'b00, BASE_REG_INDEX, 2'b00};
    localparam logic [AXI_AW-1:0] CTRL_ADDR      = 16'h0000;
    localparam logic [AXI_AW-1:0] RESH_ADDR      = 16'h0004;
    localparam logic [AXI_AW-1:0] RESL_ADDR      = 16'h0008;
    localparam logic [AXI_AW-1:0] PIN_ADDR       = 16'h000C;

    // Control register fields
    localparam int SEL_LSB  = 0;
    localparam int REPEAT_CONVERT_SELECT_BIT = 4;
    localparam int VREF_BIT = 5;
    localparam int CEN_BIT  = 7;

    // Result split: upper eight bits, then low two at the top of the low byte
    localparam int RES_LO_W = 2;
    localparam int RES_PAD  = 6;

    localparam logic [7:0]       BASE_RESET      = 8'h00;
    localparam logic [PIN_N-1:0] PIN_RESET       = 12'h000;
    localparam int               PWRUP_CYCLES    = 40;
    localparam int               IDLE_CYCLES     = 160;
    localparam int               CONV_CYCLES_DEF = 5129;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ACS_IDLE  = 2'b00,
        ACS_PWRUP = 2'b01,
        ACS_CONV  = 2'b10
    } acs_state_t;

    typedef enum logic [2:0] {
        ACS_R_CTRL = 3'b000,
        ACS_R_RESH = 3'b001,
        ACS_R_RESL = 3'b010,
        ACS_R_PIN  = 3'b011,
        ACS_R_BASE = 3'b100,
        ACS_R_NONE = 3'b111
    } acs_reg_t;

    typedef struct packed {
        logic              awvalid;
        logic [AXI_AW-1:0] awaddr;
        logic              wvalid;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bready;
        logic              arvalid;
        logic [AXI_AW-1:0] araddr;
        logic              rready;
    } acs_axil_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } acs_axil_rsp_t;

    typedef struct packed {
        logic        req;
        logic [11:0] addr;
        logic [15:0] data;
    } acs_dma_t;

    typedef struct packed {
        logic             pwr;
        logic             vref_en;
        logic [SEL_W-1:0] sel;
        logic             conv;
    } acs_afe_t;

endpackage : acs_pkg

// >>> acs_sync.sv
// Two-stage synchroniser for the converter result word
`timescale 1ns/10ps
module acs_sync (
    input  wire logic                     clk_i,
    input  wire logic                     rst_n_i,
    input  wire logic [acs_pkg::RES_W-1:0] d_i,
    output logic      [acs_pkg::RES_W-1:0] q_o
);

    typedef struct packed {
        logic [acs_pkg::RES_W-1:0] meta;
        logic [acs_pkg::RES_W-1:0] held;
    } acs_sync_t;

    acs_sync_t s_q;
    acs_sync_t s_d;

    always_comb
    begin
        s_d.meta = d_i;
        s_d.held = s_q.meta;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign q_o = s_q.held;

endmodule : acs_sync

// >>> acs_top.sv
// Conversion sequencer: register slave, conversion timing, result and DMA store
//
// Function
// - four-bit field picks one of twelve inputs
// - repeat bit zero means single-shot conversion
// - reference bit switches internal voltage reference
// - enable bit starts, reads one while busy
// - conversion lasts 5129 cycles when powered
// - forty extra power-up cycles from power-down
// - result high byte, low two at 7:6
// - enable bit clears when a single-shot conversion ends
// - single-shot completion requests an interrupt
// - power down after 160 idle cycles
// - continuous mode overwrites data each conversion
// - continuous interrupt only after first conversion
// - DMA address: base[7:1], input, zero
// - analog pin disables its digital drivers
// - one control write while idle sets all fields together
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/10ps
module acs_top #(
    parameter int CONV_CYCLES = acs_pkg::CONV_CYCLES_DEF
) (
    input  wire logic                         clk_i,
    input  wire logic                         rst_n_i,
    input  wire acs_pkg::acs_axil_req_t       axil_req_i,
    output acs_pkg::acs_axil_rsp_t            axil_rsp_o,
    input  wire logic [acs_pkg::RES_W-1:0]    adc_result_i,
    output acs_pkg::acs_afe_t                 afe_o,
    output acs_pkg::acs_dma_t                 dma_o,
    output logic                              irq_o,
    output logic      [acs_pkg::PIN_N-1:0]    pin_dig_dis_o
);

    localparam logic [acs_pkg::CNT_W-1:0] CONV_LAST  = acs_pkg::CNT_W'(CONV_CYCLES - 1);
    localparam logic [acs_pkg::CNT_W-1:0] PWRUP_LAST = acs_pkg::CNT_W'(acs_pkg::PWRUP_CYCLES - 1);
    localparam logic [7:0]                IDLE_LAST  = 8'(acs_pkg::IDLE_CYCLES - 1);

    typedef struct packed {
        acs_pkg::acs_state_t          st;
        logic [acs_pkg::CNT_W-1:0]    cnt;
        logic [7:0]                   idle_cnt;
        logic                         powered;
        logic [acs_pkg::SEL_W-1:0]    sel;
        logic                         repeat_convert_select;
        logic                         vref;
        logic                         first;
        logic [7:0]                   res_h;
        logic [7:0]                   res_l;
        logic [7:0]                   base;
        logic [acs_pkg::PIN_N-1:0]    pin_mask;
        logic                         irq;
        acs_pkg::acs_dma_t            dma;
        acs_pkg::acs_afe_t            afe;
        logic                         aw_got;
        logic [acs_pkg::AXI_AW-1:0]   aw_addr;
        logic                         w_got;
        logic [31:0]                  wdata;
        logic [3:0]                   wstrb;
        acs_pkg::acs_axil_rsp_t       rsp;
    } acs_core_t;

    ////////////////////////////////////////////////////////////////////////////
    // Reset release and input synchroniser

    logic [1:0]                rst_sync_q;
    logic                      rst_n;
    logic [acs_pkg::RES_W-1:0] res_sync;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rst_sync_q <= 2'h0;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end

    assign rst_n = rst_sync_q[1];

    acs_sync u_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n),
        .d_i     (adc_result_i),
        .q_o     (res_sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Decode helpers

    function automatic acs_pkg::acs_reg_t reg_decode(input logic [acs_pkg::AXI_AW-1:0] a);
        case (a)
            acs_pkg::CTRL_ADDR: reg_decode = acs_pkg::ACS_R_CTRL;
            acs_pkg::RESH_ADDR: reg_decode = acs_pkg::ACS_R_RESH;
            acs_pkg::RESL_ADDR: reg_decode = acs_pkg::ACS_R_RESL;
            acs_pkg::PIN_ADDR:  reg_decode = acs_pkg::ACS_R_PIN;
            acs_pkg::BASE_ADDR: reg_decode = acs_pkg::ACS_R_BASE;
            default:            reg_decode = acs_pkg::ACS_R_NONE;
        endcase
    endfunction : reg_decode

    acs_core_t s_q;
    acs_core_t s_d;

    function automatic logic [31:0] reg_read(input acs_pkg::acs_reg_t r, input acs_core_t s);
        reg_read = 32'h0000_0000;
        case (r)
            acs_pkg::ACS_R_CTRL:
            begin
                reg_read[acs_pkg::SEL_LSB +: acs_pkg::SEL_W] = s.sel;
                reg_read[acs_pkg::REPEAT_CONVERT_SELECT_BIT] = s.repeat_convert_select;
                reg_read[acs_pkg::VREF_BIT] = s.vref;
                reg_read[acs_pkg::CEN_BIT]  = (s.st != acs_pkg::ACS_IDLE);
            end
            acs_pkg::ACS_R_RESH: reg_read[7:0] = s.res_h;
            acs_pkg::ACS_R_RESL: reg_read[7:0] = s.res_l;
            acs_pkg::ACS_R_PIN:  reg_read[acs_pkg::PIN_N-1:0] = s.pin_mask;
            acs_pkg::ACS_R_BASE: reg_read[7:0] = s.base;
            default:             reg_read = 32'h0000_0000;
        endcase
    endfunction : reg_read

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    logic             aw_fire;
    logic             w_fire;
    logic             ar_fire;
    logic             wr_go;
    logic             start;
    logic             stop;
    logic             done;
    acs_pkg::acs_reg_t wr_idx;

    always_comb
    begin
        s_d         = s_q;
        s_d.irq     = 1'b0;
        s_d.dma.req = 1'b0;
        start       = 1'b0;
        stop        = 1'b0;
        done        = 1'b0;
        aw_fire     = axil_req_i.awvalid && s_q.rsp.awready;
        w_fire      = axil_req_i.wvalid && s_q.rsp.wready;
        ar_fire     = axil_req_i.arvalid && s_q.rsp.arready;

        if (s_q.rsp.bvalid && axil_req_i.bready)
            s_d.rsp.bvalid = 1'b0;
        if (aw_fire)
        begin
            s_d.aw_got  = 1'b1;
            s_d.aw_addr = axil_req_i.awaddr;
        end
        if (w_fire)
        begin
            s_d.w_got = 1'b1;
            s_d.wdata = axil_req_i.wdata;
            s_d.wstrb = axil_req_i.wstrb;
        end
        wr_go  = s_d.aw_got && s_d.w_got;
        wr_idx = reg_decode(s_d.aw_addr);
        if (wr_go)
        begin
            s_d.aw_got     = 1'b0;
            s_d.w_got      = 1'b0;
            s_d.rsp.bvalid = 1'b1;
            s_d.rsp.bresp  = (wr_idx == acs_pkg::ACS_R_NONE) ? acs_pkg::RESP_SLVERR
                                                             : acs_pkg::RESP_OKAY;
            if (s_d.wstrb[0])
            begin
                case (wr_idx)
                    acs_pkg::ACS_R_CTRL:
                    begin
                        // Fields only change while idle, so a running conversion is stable
                        if (s_q.st == acs_pkg::ACS_IDLE)
                        begin
                            s_d.sel  = s_d.wdata[acs_pkg::SEL_LSB +: acs_pkg::SEL_W];
                            s_d.repeat_convert_select = s_d.wdata[acs_pkg::REPEAT_CONVERT_SELECT_BIT];
                            s_d.vref = s_d.wdata[acs_pkg::VREF_BIT];
                            start    = s_d.wdata[acs_pkg::CEN_BIT];
                        end
                        else
                            stop = !s_d.wdata[acs_pkg::CEN_BIT];
                    end
                    acs_pkg::ACS_R_PIN:  s_d.pin_mask[7:0] = s_d.wdata[7:0];
                    acs_pkg::ACS_R_BASE: s_d.base = s_d.wdata[7:0];
                    default:             s_d.base = s_q.base;
                endcase
            end
            if (s_d.wstrb[1] && wr_idx == acs_pkg::ACS_R_PIN)
                s_d.pin_mask[acs_pkg::PIN_N-1:8] = s_d.wdata[acs_pkg::PIN_N-1:8];
        end

        if (s_q.rsp.rvalid && axil_req_i.rready)
            s_d.rsp.rvalid = 1'b0;
        if (ar_fire)
        begin
            s_d.rsp.rvalid = 1'b1;
            s_d.rsp.rdata  = reg_read(reg_decode(axil_req_i.araddr), s_q);
            s_d.rsp.rresp  = (reg_decode(axil_req_i.araddr) == acs_pkg::ACS_R_NONE)
                             ? acs_pkg::RESP_SLVERR : acs_pkg::RESP_OKAY;
        end
        s_d.rsp.awready = !s_d.aw_got && !s_d.rsp.bvalid;
        s_d.rsp.wready  = !s_d.w_got && !s_d.rsp.bvalid;
        s_d.rsp.arready = !s_d.rsp.rvalid;

        case (s_q.st)
            acs_pkg::ACS_IDLE:
            begin
                if (start)
                begin
                    s_d.first    = 1'b1;
                    s_d.idle_cnt = 8'h00;
                    if (s_q.powered)
                    begin
                        s_d.st  = acs_pkg::ACS_CONV;
                        s_d.cnt = CONV_LAST;
                    end
                    else
                    begin
                        s_d.st  = acs_pkg::ACS_PWRUP;
                        s_d.cnt = PWRUP_LAST;
                    end
                end
                else if (s_q.powered)
                begin
                    if (s_q.idle_cnt == IDLE_LAST)
                    begin
                        s_d.powered  = 1'b0;
                        s_d.idle_cnt = 8'h00;
                    end
                    else
                        s_d.idle_cnt = s_q.idle_cnt + 8'h01;
                end
            end
            acs_pkg::ACS_PWRUP:
            begin
                if (stop)
                    s_d.st = acs_pkg::ACS_IDLE;
                else if (s_q.cnt == '0)
                begin
                    s_d.st      = acs_pkg::ACS_CONV;
                    s_d.cnt     = CONV_LAST;
                    s_d.powered = 1'b1;
                end
                else
                    s_d.cnt = s_q.cnt - 1'b1;
            end
            acs_pkg::ACS_CONV:
            begin
                if (stop)
                    s_d.st = acs_pkg::ACS_IDLE;
                else if (s_q.cnt == '0)
                begin
                    done  = 1'b1;
                    // Previous result is simply overwritten, no overrun flag
                    {s_d.res_h, s_d.res_l[7 -: acs_pkg::RES_LO_W]} = res_sync;
                    s_d.res_l[acs_pkg::RES_PAD-1:0] = '0;
                    s_d.irq   = s_q.first;
                    s_d.first = 1'b0;
                    s_d.dma.req  = 1'b1;
                    // Base bit zero is dropped; software keeps it zero anyway
                    s_d.dma.addr = {s_q.base[7:1], s_q.sel, 1'b0};
                    s_d.dma.data = {res_sync, {acs_pkg::RES_PAD{1'b0}}};
                    if (s_q.repeat_convert_select)
                        s_d.cnt = CONV_LAST;
                    else
                        s_d.st = acs_pkg::ACS_IDLE;
                end
                else
                    s_d.cnt = s_q.cnt - 1'b1;
            end
            default: s_d.st = acs_pkg::ACS_IDLE;
        endcase

        s_d.afe.pwr     = s_d.powered || (s_d.st != acs_pkg::ACS_IDLE);
        s_d.afe.vref_en = s_d.vref;
        s_d.afe.sel     = s_d.sel;
        s_d.afe.conv    = (s_d.st == acs_pkg::ACS_CONV);
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q          <= '0;
            s_q.base     <= acs_pkg::BASE_RESET;
            s_q.pin_mask <= acs_pkg::PIN_RESET;
        end
        else
            s_q <= s_d;
    end

    assign axil_rsp_o    = s_q.rsp;
    assign afe_o         = s_q.afe;
    assign dma_o         = s_q.dma;
    assign irq_o         = s_q.irq;
    assign pin_dig_dis_o = s_q.pin_mask;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    logic [acs_pkg::CNT_W-1:0] conv_cyc_q;
    logic [acs_pkg::CNT_W-1:0] pwr_cyc_q;

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            conv_cyc_q <= '0;
            pwr_cyc_q  <= '0;
        end
        else
        begin
            // Count from zero in the first cycle of each phase
            conv_cyc_q <= (s_q.st == acs_pkg::ACS_CONV && s_d.st == acs_pkg::ACS_CONV && !done)
                          ? conv_cyc_q + 1'b1 : '0;
            pwr_cyc_q  <= (s_q.st == acs_pkg::ACS_PWRUP && s_d.st == acs_pkg::ACS_PWRUP)
                          ? pwr_cyc_q + 1'b1 : '0;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n);

    a_start_busy_flag: assert property (
        (s_q.st == acs_pkg::ACS_IDLE && start) |=> afe_o.pwr && s_q.st != acs_pkg::ACS_IDLE)
        else $error("start did not make the sequencer busy");
    a_conv_cycle_count: assert property (
        done |-> conv_cyc_q == CONV_LAST)
        else $error("conversion length wrong");
    a_pwrup_cycle_count: assert property (
        (s_q.st == acs_pkg::ACS_PWRUP && s_d.st == acs_pkg::ACS_CONV)
        |-> pwr_cyc_q == PWRUP_LAST)
        else $error("power-up length wrong");
    a_result_byte_map: assert property (
        done |=> s_q.res_h == $past(res_sync[acs_pkg::RES_W-1:2])
                 && s_q.res_l[7:6] == $past(res_sync[1:0]) && s_q.res_l[5:0] == 6'h00)
        else $error("result bytes misplaced");
    a_enable_clears: assert property (
        (done && !s_q.repeat_convert_select) |=> s_q.st == acs_pkg::ACS_IDLE ##1 !s_q.afe.conv)
        else $error("enable bit did not clear");
    a_single_irq: assert property (
        (done && !s_q.repeat_convert_select) |=> irq_o && dma_o.req)
        else $error("single-shot interrupt missing");
    a_idle_power_down: assert property (
        (s_q.st == acs_pkg::ACS_IDLE && s_q.powered && !start && s_q.idle_cnt == IDLE_LAST)
        |=> !afe_o.pwr)
        else $error("idle power-down missed");
    a_repeat_convert_select_repeat: assert property (
        (done && s_q.repeat_convert_select && !stop) |=> s_q.st == acs_pkg::ACS_CONV && conv_cyc_q == '0)
        else $error("continuous mode did not restart");
    a_repeat_convert_select_irq_once: assert property (
        (done && !s_q.first) |=> !irq_o)
        else $error("repeat interrupt in continuous mode");
    a_dma_address: assert property (
        dma_o.req |-> dma_o.addr == {s_q.base[7:1], s_q.sel, 1'b0})
        else $error("DMA store address wrong");

    c_single_done: cover property (done && !s_q.repeat_convert_select);
    c_repeat_convert_select_second: cover property (done && s_q.repeat_convert_select && !s_q.first);
    c_power_up: cover property (s_q.st == acs_pkg::ACS_PWRUP ##1 s_q.st == acs_pkg::ACS_CONV);
    c_power_down: cover property ($fell(s_q.powered));

endmodule : acs_top

// >>> acs_afe_model.sv
// Behavioural converter front end that feeds result words to the sequencer
`timescale 1ns/10ps
module acs_afe_model (
    input  wire logic                      clk_i,
    input  wire logic                      rst_n_i,
    input  wire acs_pkg::acs_afe_t         afe_i,
    output logic      [acs_pkg::RES_W-1:0] result_o,
    output logic      [5:0]                count_o
);
    logic                      conv_q;
    logic [acs_pkg::RES_W-1:0] junk_q;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            conv_q  <= 1'b0;
            count_o <= 6'h00;
            junk_q  <= 10'h155;
        end
        else
        begin
            conv_q <= afe_i.conv;
            junk_q <= ~junk_q;
            if (afe_i.conv && !conv_q)
                count_o <= count_o + 6'h01;
        end
    end

    // Word carries the selected input so a wrong mux shows up
    // Outside a powered conversion the word toggles, so stale sampling is caught
    assign result_o = (afe_i.pwr && afe_i.conv) ? {afe_i.sel, count_o} : junk_q;
endmodule : acs_afe_model

// >>> acs_top_tb.sv
// Self-checking bench of the conversion sequencer over its register bus
`timescale 1ns/10ps
module acs_top_tb;
    localparam int CONV = 20;
    logic                   clk_i;
    logic                   rst_n_i;
    acs_pkg::acs_axil_req_t req;
    acs_pkg::acs_axil_rsp_t rsp;
    acs_pkg::acs_afe_t      afe;
    acs_pkg::acs_dma_t      dma;
    logic                   irq;
    logic [11:0]            pins;
    logic [9:0]             adc;
    logic [5:0]             mcnt;
    logic [5:0]             last_cnt;
    logic                   bv_q;
    logic [31:0]            rd;
    logic [1:0]             rs;
    logic [9:0]             e;
    int                     bad_count;
    int                     n_compared;
    int                     cyc;
    int                     t_b;
    int                     t_irq;
    int                     n_irq;
    int                     n_dma;
    int                     n0;
    int                     k;

    acs_top #(.CONV_CYCLES(CONV)) dut_u (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .axil_req_i(req), .axil_rsp_o(rsp),
        .adc_result_i(adc), .afe_o(afe), .dma_o(dma), .irq_o(irq), .pin_dig_dis_o(pins));

    acs_afe_model model_u (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .afe_i(afe), .result_o(adc), .count_o(mcnt));

    initial
    begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Event monitor: cycle stamps of write responses and interrupts, counts of interrupts and DMA requests
    always @(posedge clk_i)
    begin
        cyc  <= cyc + 1;
        bv_q <= rsp.bvalid;
        if (rsp.bvalid && !bv_q)
            t_b <= cyc;
        if (irq)
        begin
            t_irq <= cyc;
            n_irq <= n_irq + 1;
        end
        if (dma.req)
        begin
            n_dma    <= n_dma + 1;
            last_cnt <= mcnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            bad_count++;
        end
    endtask : chk

    task automatic axi_write(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk_i);
        req.awaddr  <= a;
        req.wdata   <= d;
        req.wstrb   <= 4'hF;
        req.awvalid <= 1'b1;
        req.wvalid  <= 1'b1;
        req.bready  <= 1'b1;
        do
        begin
            @(posedge clk_i);
            if (req.awvalid && rsp.awready)
                req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready)
                req.wvalid <= 1'b0;
        end
        while (!(req.bready && rsp.bvalid));
        r = rsp.bresp;
        req.bready <= 1'b0;
    endtask : axi_write

    task automatic axi_read(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_i);
        req.araddr  <= a;
        req.arvalid <= 1'b1;
        req.rready  <= 1'b1;
        do
        begin
            @(posedge clk_i);
            if (req.arvalid && rsp.arready)
                req.arvalid <= 1'b0;
        end
        while (!(req.rready && rsp.rvalid));
        d = rsp.rdata;
        r = rsp.rresp;
        req.rready <= 1'b0;
    endtask : axi_read

    // Write one control word, then wait a bounded time for its interrupt
    task automatic shot(input logic [7:0] ctrl, input int lat);
        int n;
        n  = 0;
        n0 = n_irq;
        axi_write(acs_pkg::CTRL_ADDR, {24'h0, ctrl}, rs);
        chk(afe.sel, ctrl[3:0]);
        chk(afe.vref_en, ctrl[5]);
        while (n_irq == n0 && n < 500)
        begin
            @(posedge clk_i);
            n++;
        end
        chk(t_irq - t_b, lat);
        e = {ctrl[3:0], last_cnt};
        chk(dma.addr, {7'h39, ctrl[3:0], 1'b0});
        chk(dma.data, {e, 6'h00});
    endtask : shot

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : final_report

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (5000) @(posedge clk_i);
        bad_count++;
        final_report();
    end

    initial
    begin
        req = '0;
        rst_n_i = 1'b0;
        {bad_count, n_compared, cyc, t_b, t_irq, n_irq, n_dma} = '0;
        bv_q = 1'b0;
        last_cnt = 6'h00;
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        axi_read(acs_pkg::CTRL_ADDR, rd, rs);
        chk(rd, 32'h0);
        axi_read(acs_pkg::BASE_ADDR, rd, rs);
        chk(rd, {24'h0, acs_pkg::BASE_RESET});
        axi_read(16'h0010, rd, rs);
        chk(rs, acs_pkg::RESP_SLVERR);
        chk(rd, 32'h0);
        axi_write(16'h0010, 32'h0000_00FF, rs);
        chk(rs, acs_pkg::RESP_SLVERR);
        axi_write(acs_pkg::PIN_ADDR, 32'h0000_0A5C, rs);
        chk(pins, 12'hA5C);
        axi_write(acs_pkg::BASE_ADDR, 32'h0000_0072, rs);
        axi_read(acs_pkg::BASE_ADDR, rd, rs);
        chk(rd, 32'h0000_0072);
        // First start comes from power-down, so it carries the wake-up time
        shot(8'hA5, 40 + CONV);
        axi_read(acs_pkg::RESH_ADDR, rd, rs);
        chk(rd, {24'h0, e[9:2]});
        axi_read(acs_pkg::RESL_ADDR, rd, rs);
        chk(rd, {24'h0, e[1:0], 6'h00});
        axi_read(acs_pkg::CTRL_ADDR, rd, rs);
        chk(rd, 32'h0000_0025);
        for (int s = 0; s < acs_pkg::PIN_N; s++)
            shot({4'h8, s[3:0]}, CONV);
        repeat (140) @(posedge clk_i);
        chk(afe.pwr, 1'b1);
        repeat (30) @(posedge clk_i);
        chk(afe.pwr, 1'b0);
        // Continuous run on the last input, then stop it mid-stream
        n0 = n_irq;
        k  = n_dma;
        axi_write(acs_pkg::CTRL_ADDR, 32'h0000_009B, rs);
        axi_read(acs_pkg::CTRL_ADDR, rd, rs);
        chk(rd, 32'h0000_009B);
        for (int n = 0; n < 1000 && n_dma < k + 3; n++)
            @(posedge clk_i);
        chk(n_dma - k, 3);
        chk(n_irq, n0 + 1);
        axi_write(acs_pkg::CTRL_ADDR, 32'h0000_001B, rs);
        repeat (60) @(posedge clk_i);
        chk(n_irq, n0 + 1);
        axi_read(acs_pkg::CTRL_ADDR, rd, rs);
        chk(rd, 32'h0000_001B);
        e = {4'hB, last_cnt};
        axi_read(acs_pkg::RESH_ADDR, rd, rs);
        chk(rd, {24'h0, e[9:2]});
        chk(dma.addr, 12'h736);
        final_report();
    end
endmodule : acs_top_tb
